// ---- bench/dtl_host_model.sv ----
/*
  Host controller model: offers writes on the core's write port, one at a
  time, holding each until the core's ready is seen high at a rising edge or 200 rising edges pass.
  Assumes the bench calls put and that every change lands at a falling edge.
*/
`timescale 1ns/1ps
module dtl_host_model (
  // clock and handshake
  input wire logic clk_i,
  input wire logic wr_ready_i,
  // write port
  output logic wr_valid_o,
  output dtl_pkg::dtl_wr_kind_t wr_kind_o,
  output logic wr_all_o,
  output logic [dtl_pkg::CH_W-1:0] wr_chan_o,
  output logic [dtl_pkg::CODE_W-1:0] wr_data_o,
  output logic bank_b_o
);
  // idle bus at time zero
  initial begin
    wr_valid_o = 1'b0;
    wr_kind_o = dtl_pkg::DTL_WR_RAW;
    wr_all_o = 1'b0;
    wr_chan_o = 5'h00;
    wr_data_o = 16'h0000;
    bank_b_o = 1'b0;
  end

  // one write; on release, data and channel show inverted values so nothing stale passes
  task automatic put(input dtl_pkg::dtl_wr_kind_t k, input logic a,
                     input logic [4:0] c, input logic [15:0] d, input logic b);
    int n;
    n = 0;
    @(negedge clk_i);
    wr_valid_o = 1'b1;
    wr_kind_o = k;
    wr_all_o = a;
    wr_chan_o = c;
    wr_data_o = d;
    bank_b_o = b;
    do begin
      @(posedge clk_i);
      n++;
    end while (wr_ready_i !== 1'b1 && n < 200);
    @(negedge clk_i);
    wr_valid_o = 1'b0;
    wr_data_o = ~d;
    wr_chan_o = ~c;
  endtask
endmodule

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the trim and load core: a model built from the
  transfer rules tracks trimmed banks, selects, spans and dac registers.
  Assumes the core's short init count is set to 8 cycles.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int INIT_N = 8;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic load_strobe_n_i = 1'b1;
  logic output_hold_n_i = 1'b1;
  logic wr_valid, wr_all, bank_b, wr_ready_o, outputs_connected_o, recalc_busy_o;
  dtl_pkg::dtl_wr_kind_t wr_kind;
  logic [4:0] wr_chan;
  logic [15:0] wr_data;
  logic [31:0][15:0] dac_code_o;
  logic [31:0][17:0] net_code_o;
  int raw_a[32], raw_b[32], gain[32], offs[32], x2a[32], x2b[32], dac_m[32];
  int span[2];
  logic [31:0] selv = 32'h0;
  int seed, mismatches, num_checks, n;
  int picks[4] = '{0, 7, 8, 31};

  always #2.5 clk_i = ~clk_i;

  dtl_host_model dtl_host_model_inst (.clk_i(clk_i), .wr_ready_i(wr_ready_o),
    .wr_valid_o(wr_valid), .wr_kind_o(wr_kind), .wr_all_o(wr_all),
    .wr_chan_o(wr_chan), .wr_data_o(wr_data), .bank_b_o(bank_b));
  dtl_dac_core #(.INIT_CYCLES(INIT_N)) dtl_dac_core_inst (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .wr_valid_i(wr_valid), .wr_ready_o(wr_ready_o),
    .wr_kind_i(wr_kind), .wr_all_i(wr_all), .wr_chan_i(wr_chan), .wr_data_i(wr_data),
    .bank_b_i(bank_b), .load_strobe_n_i(load_strobe_n_i),
    .output_hold_n_i(output_hold_n_i), .outputs_connected_o(outputs_connected_o),
    .recalc_busy_o(recalc_busy_o), .dac_code_o(dac_code_o), .net_code_o(net_code_o));

  // truncating multiply, then clamp instead of wrapping
  function automatic int trim(input int r, input int g, input int o);
    longint p;
    longint top;
    top = (longint'(1) <<< dtl_pkg::CODE_W) - 1;
    p = (longint'(r) * longint'(g + 1)) >>> dtl_pkg::CODE_W;
    p = p + o - (top + 1) / 2;
    return (p < 0) ? 0 : ((p > top) ? int'(top) : int'(p));
  endfunction

  function automatic int rnd();
    return $random(seed) & 32'hffff;
  endfunction

  task automatic miss(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_code(input logic [15:0] got, input logic [15:0] exp);
    miss({2'b00, got}, {2'b00, exp});
  endtask
  task automatic chk_net(input logic [17:0] got, input logic [17:0] exp);
    miss(got, exp);
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    miss({17'h0, got}, {17'h0, exp});
  endtask

  // write through the host and mirror it in the model
  task automatic mw(input dtl_pkg::dtl_wr_kind_t k, input logic a, input int ch,
                    input int d, input logic b);
    dtl_host_model_inst.put(k, a, 5'(ch), 16'(d), b);
    if (k == dtl_pkg::DTL_WR_SPAN0 || k == dtl_pkg::DTL_WR_SPAN1) begin
      span[k == dtl_pkg::DTL_WR_SPAN1] = d & 32'h3fff;
    end else if (k == dtl_pkg::DTL_WR_SELECT) begin
      for (int i = 0; i < 8; i++) selv[(ch / 8) * 8 + i] = d[i];
    end else begin
      for (int c = (a ? 0 : ch); c <= (a ? 31 : ch); c++) begin
        if (k == dtl_pkg::DTL_WR_RAW && b) raw_b[c] = d;
        if (k == dtl_pkg::DTL_WR_RAW && !b) raw_a[c] = d;
        if (k == dtl_pkg::DTL_WR_GAIN) gain[c] = d;
        if (k == dtl_pkg::DTL_WR_OFFSET) offs[c] = d;
        if (b) x2b[c] = trim(raw_b[c], gain[c], offs[c]);
        else x2a[c] = trim(raw_a[c], gain[c], offs[c]);
      end
    end
  endtask

  task automatic latch();
    for (int c = 0; c < 32; c++) dac_m[c] = selv[c] ? x2b[c] : x2a[c];
  endtask

  task automatic check_all();
    for (int c = 0; c < 32; c++) begin
      chk_code(dac_code_o[c], 16'(dac_m[c]));
      chk_net(net_code_o[c], 18'(dac_m[c] - span[c > 7] * 4));
    end
  endtask

  // the shared trim unit runs channels in turn; wait it out under a bound
  task automatic settle();
    int k;
    k = 0;
    repeat (2) @(negedge clk_i);
    while (recalc_busy_o !== 1'b0 && k < 400) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 400) mismatches++;
    repeat (2) @(negedge clk_i);
  endtask

  // one low sample of the strobe, then look after the net code lands
  task automatic load_pulse();
    @(negedge clk_i);
    load_strobe_n_i = 1'b0;
    @(negedge clk_i);
    load_strobe_n_i = 1'b1;
    latch();
    @(negedge clk_i);
    check_all();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    end_of_test();
  end

  initial begin
    seed = 75070;
    span = '{32'h1555, 32'h1555};
    for (int c = 0; c < 32; c++) begin
      raw_a[c] = 32'h5554;
      raw_b[c] = 32'h5554;
      gain[c] = 32'hffff;
      offs[c] = 32'h8000;
      x2a[c] = trim(32'h5554, 32'hffff, 32'h8000);
      x2b[c] = x2a[c];
      dac_m[c] = x2a[c];
    end
    repeat (3) @(negedge clk_i);
    chk_code(dac_code_o[31], 16'h5554);
    chk_bit(outputs_connected_o, 1'b0);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    chk_bit(wr_ready_o, 1'b0);
    chk_bit(outputs_connected_o, 1'b0);
    n = 0;
    while (wr_ready_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    repeat (2) @(negedge clk_i);
    chk_bit(outputs_connected_o, 1'b1);
    check_all();
    // group edge channels, both banks, strobe idle: dac must not move
    for (int i = 0; i < 8; i++) begin
      mw(dtl_pkg::DTL_WR_RAW, 1'b0, picks[i % 4], rnd(), i > 3);
      mw(dtl_pkg::DTL_WR_GAIN, 1'b0, picks[i % 4], rnd(), i[0]);
      mw(dtl_pkg::DTL_WR_OFFSET, 1'b0, picks[i % 4], rnd(), i[1]);
    end
    settle();
    check_all();
    load_pulse();
    mw(dtl_pkg::DTL_WR_SPAN0, 1'b0, 0, rnd() & 32'h1fff, 1'b0);
    mw(dtl_pkg::DTL_WR_SPAN1, 1'b0, 8, 32'h2000, 1'b0);
    load_pulse();
    for (int g = 0; g < 4; g++) mw(dtl_pkg::DTL_WR_SELECT, 1'b0, g * 8, rnd() & 32'hff, 1'b0);
    load_pulse();
    mw(dtl_pkg::DTL_WR_RAW, 1'b1, 0, rnd(), 1'b1);
    mw(dtl_pkg::DTL_WR_RAW, 1'b1, 0, rnd(), 1'b0);
    settle();
    load_pulse();
    // outputs held while registers stay programmable, strobe tied low
    output_hold_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk_bit(outputs_connected_o, 1'b0);
    mw(dtl_pkg::DTL_WR_GAIN, 1'b0, 3, 32'hffff - 273, 1'b0);
    mw(dtl_pkg::DTL_WR_OFFSET, 1'b0, 3, 32'h8000 + 164, 1'b0);
    load_strobe_n_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      mw(dtl_pkg::dtl_wr_kind_t'(rnd() % 3), 1'b0, rnd() % 32, rnd(), rnd() & 1);
      chk_bit(recalc_busy_o, 1'b1);
      settle();
      latch();
      repeat (2) @(negedge clk_i);
      check_all();
    end
    output_hold_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk_bit(outputs_connected_o, 1'b1);
    end_of_test();
  end
endmodule

// ---- verilog/dtl_dac_core.sv ----
/*
  DAC trim and load datapath: per-channel input, gain and offset words, the
  two trimmed banks, bank select, span codes and the final DAC registers.
  Assumes the host write port is synchronous to clk_i and that only one
  write is offered per cycle.
*/
`timescale 1ns/1ps
module dtl_dac_core #(
  parameter int INIT_CYCLES = dtl_pkg::INIT_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // host write port
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire dtl_pkg::dtl_wr_kind_t wr_kind_i,
  input wire logic wr_all_i,
  input wire logic [dtl_pkg::CH_W-1:0] wr_chan_i,
  input wire logic [dtl_pkg::CODE_W-1:0] wr_data_i,
  // global bank choice, 0 = bank a, 1 = bank b
  input wire logic bank_b_i,
  // load and hold pins
  input wire logic load_strobe_n_i,
  input wire logic output_hold_n_i,
  // dac side
  output logic outputs_connected_o,
  output logic recalc_busy_o,
  output logic [dtl_pkg::CH_N-1:0][dtl_pkg::CODE_W-1:0] dac_code_o,
  output logic [dtl_pkg::CH_N-1:0][dtl_pkg::NET_W-1:0] net_code_o
);

  localparam int N = dtl_pkg::CH_N;
  localparam int W = dtl_pkg::CODE_W;
  localparam int INIT_W = $clog2(INIT_CYCLES + 1);

  logic [N-1:0][W-1:0] input_word_a;
  logic [N-1:0][W-1:0] input_word_b;
  logic [N-1:0][W-1:0] gain_trim;
  logic [N-1:0][W-1:0] offset_trim;
  logic [N-1:0][W-1:0] trimmed_word_a;
  logic [N-1:0][W-1:0] trimmed_word_b;
  logic [dtl_pkg::GROUP_N-1:0][7:0] bank_select;
  logic [dtl_pkg::SPAN_W-1:0] span_code0;
  logic [dtl_pkg::SPAN_W-1:0] span_code1;
  logic [N-1:0] pend_a;
  logic [N-1:0] pend_b;
  logic [N-1:0] hit;
  logic [INIT_W-1:0] init_count;
  logic init_done;
  logic wr_fire;
  dtl_pkg::dtl_seq_state_t seq_state;
  logic [dtl_pkg::CH_W-1:0] seq_chan;
  logic seq_bank_b;
  logic [dtl_pkg::CH_W-1:0] next_chan;
  logic next_bank_b;
  logic next_found;

  dtl_trim_if trim ();

  // span code aligned to code resolution
  function automatic logic [dtl_pkg::NET_W-1:0] span_aligned(
      input logic [dtl_pkg::SPAN_W-1:0] code);
    span_aligned = dtl_pkg::NET_W'(code) << dtl_pkg::SPAN_SHIFT;
  endfunction

  // upper groups share the second span code
  function automatic logic upper_group(input int ch);
    upper_group = (ch >= dtl_pkg::GROUP_SIZE);
  endfunction

  // init sequence; writes refused until it ends so defaults settle first
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      init_count <= '0;
      init_done <= 1'b0;
    end else if (!init_done) begin
      init_count <= init_count + INIT_W'(1);
      init_done <= (init_count == INIT_W'(INIT_CYCLES - 1));
    end
  end

  assign wr_ready_o = init_done;
  assign wr_fire = wr_valid_i && init_done;
  assign recalc_busy_o = (seq_state != dtl_pkg::DTL_SEQ_IDLE) || (|pend_a) || (|pend_b);

  // output switch: disconnected while held or initialising
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      outputs_connected_o <= 1'b0;
    end else begin
      outputs_connected_o <= init_done && output_hold_n_i;
    end
  end

  // write hit mask, one channel or all of them
  always_comb begin
    for (int c = 0; c < N; c++) begin
      hit[c] = wr_fire && (wr_all_i || (wr_chan_i == dtl_pkg::CH_W'(c)));
    end
  end

  // per-channel input and trim words; bank pin steers raw writes
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int c = 0; c < N; c++) begin
        input_word_a[c] <= dtl_pkg::RAW_DEFAULT;
        input_word_b[c] <= dtl_pkg::RAW_DEFAULT;
        gain_trim[c] <= dtl_pkg::GAIN_DEFAULT;
        offset_trim[c] <= dtl_pkg::OFFSET_DEFAULT;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (hit[c] && wr_kind_i == dtl_pkg::DTL_WR_RAW && !bank_b_i) input_word_a[c] <= wr_data_i;
        if (hit[c] && wr_kind_i == dtl_pkg::DTL_WR_RAW && bank_b_i) input_word_b[c] <= wr_data_i;
        if (hit[c] && wr_kind_i == dtl_pkg::DTL_WR_GAIN) gain_trim[c] <= wr_data_i;
        if (hit[c] && wr_kind_i == dtl_pkg::DTL_WR_OFFSET) offset_trim[c] <= wr_data_i;
      end
    end
  end

  // span codes and bank selects
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      span_code0 <= dtl_pkg::SPAN_DEFAULT;
      span_code1 <= dtl_pkg::SPAN_DEFAULT;
      bank_select <= '0;
    end else if (wr_fire) begin
      if (wr_kind_i == dtl_pkg::DTL_WR_SPAN0) span_code0 <= wr_data_i[dtl_pkg::SPAN_W-1:0];
      if (wr_kind_i == dtl_pkg::DTL_WR_SPAN1) span_code1 <= wr_data_i[dtl_pkg::SPAN_W-1:0];
      if (wr_kind_i == dtl_pkg::DTL_WR_SELECT) begin
        bank_select[wr_chan_i[4:3]] <= wr_data_i[7:0];
      end
    end
  end

  // pending bits drop at launch, so a rewrite while in flight re-pends;
  // a new write beats the clear of its own bit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_a <= '0;
      pend_b <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (trim.start && !next_bank_b && next_chan == dtl_pkg::CH_W'(c)) pend_a[c] <= 1'b0;
        if (trim.start && next_bank_b && next_chan == dtl_pkg::CH_W'(c)) pend_b[c] <= 1'b0;
        if (hit[c] && wr_kind_i inside {dtl_pkg::DTL_WR_RAW, dtl_pkg::DTL_WR_GAIN,
            dtl_pkg::DTL_WR_OFFSET}) begin
          if (bank_b_i) pend_b[c] <= 1'b1;
          else pend_a[c] <= 1'b1;
        end
      end
    end
  end

  // lowest pending channel, bank a before bank b
  always_comb begin
    next_chan = '0;
    next_bank_b = 1'b0;
    next_found = 1'b0;
    for (int c = N - 1; c >= 0; c--) begin
      if (pend_b[c]) begin
        next_chan = dtl_pkg::CH_W'(c);
        next_bank_b = 1'b1;
        next_found = 1'b1;
      end
    end
    for (int c = N - 1; c >= 0; c--) begin
      if (pend_a[c]) begin
        next_chan = dtl_pkg::CH_W'(c);
        next_bank_b = 1'b0;
        next_found = 1'b1;
      end
    end
  end

  // sequencer: one channel at a time through the shared trim unit
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_state <= dtl_pkg::DTL_SEQ_IDLE;
      seq_chan <= '0;
      seq_bank_b <= 1'b0;
    end else begin
      unique case (seq_state)
        dtl_pkg::DTL_SEQ_IDLE: begin
          if (next_found) begin
            seq_chan <= next_chan;
            seq_bank_b <= next_bank_b;
            seq_state <= dtl_pkg::DTL_SEQ_WAIT;
          end
        end
        dtl_pkg::DTL_SEQ_WAIT: begin
          if (trim.done) seq_state <= dtl_pkg::DTL_SEQ_IDLE;
        end
        default: seq_state <= dtl_pkg::DTL_SEQ_IDLE;
      endcase
    end
  end

  // operands are read live at start; a rewrite in flight re-pends the channel
  assign trim.start = (seq_state == dtl_pkg::DTL_SEQ_IDLE) && next_found;
  assign trim.raw = next_bank_b ? input_word_b[next_chan] : input_word_a[next_chan];
  assign trim.gain = gain_trim[next_chan];
  assign trim.offset = offset_trim[next_chan];

  dtl_trim_unit u_trim (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .trim(trim.unit)
  );

  // trimmed banks, never written from the host port directly
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trimmed_word_a <= {N{dtl_pkg::RAW_DEFAULT}};
      trimmed_word_b <= {N{dtl_pkg::RAW_DEFAULT}};
    end else if (trim.done) begin
      if (seq_bank_b) trimmed_word_b[seq_chan] <= trim.result;
      else trimmed_word_a[seq_chan] <= trim.result;
    end
  end

  // dac registers follow the selected bank while the strobe is low;
  // a falling edge and a held-low strobe are the same case here
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_code_o <= {N{dtl_pkg::RAW_DEFAULT}};
    end else if (!load_strobe_n_i) begin
      for (int c = 0; c < N; c++) begin
        dac_code_o[c] <= bank_select[c / 8][c % 8] ? trimmed_word_b[c] : trimmed_word_a[c];
      end
    end
  end

  // code relative to the group span, as seen by the output stage
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      net_code_o <= '0;
    end else begin
      for (int c = 0; c < N; c++) begin
        net_code_o[c] <= dtl_pkg::NET_W'(dac_code_o[c])
          - span_aligned(upper_group(c) ? span_code1 : span_code0);
      end
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_load_copy_ch9: assert property (
    !load_strobe_n_i |=> dac_code_o[9] ==
      ($past(bank_select[1][1]) ? $past(trimmed_word_b[9]) : $past(trimmed_word_a[9])))
    else $error("dac register missed the selected trimmed word");
  a_dac_no_direct: assert property (
    load_strobe_n_i |=> $stable(dac_code_o))
    else $error("dac register changed without the load strobe");
  a_follow_new_data: assert property (
    !load_strobe_n_i && trim.done && seq_bank_b == bank_select[seq_chan[4:3]][seq_chan[2:0]]
      ##1 !load_strobe_n_i && $stable(bank_select)
      |=> dac_code_o[$past(seq_chan, 2)] == $past(trim.result, 2))
    else $error("held strobe did not pass new data through");
  a_span_default: assert property (
    !init_done |-> span_code0 == 14'h1555 && span_code1 == 14'h1555)
    else $error("span code not at its default during init");
  a_span_align_ch0: assert property (
    1'b1 |=> net_code_o[0] == dtl_pkg::NET_W'($past(dac_code_o[0]))
      - (dtl_pkg::NET_W'($past(span_code0)) << 2))
    else $error("group zero span not scaled before subtraction");
  a_upper_group_span: assert property (
    1'b1 |=> net_code_o[8] == dtl_pkg::NET_W'($past(dac_code_o[8]))
      - (dtl_pkg::NET_W'($past(span_code1)) << 2))
    else $error("channel eight not on the upper span code");
  a_hold_disconnects: assert property (
    !output_hold_n_i |=> !outputs_connected_o)
    else $error("outputs connected while hold is low");
  a_init_holds_out: assert property (
    !init_done |=> !outputs_connected_o ##0 dac_code_o[3] == dtl_pkg::RAW_DEFAULT)
    else $error("outputs released before initialisation ended");
  a_write_pends_a: assert property (
    wr_fire && !wr_all_i && wr_kind_i == dtl_pkg::DTL_WR_GAIN && !bank_b_i
      |=> pend_a[$past(wr_chan_i)])
    else $error("trim write did not schedule a bank a recalculation");
  a_one_at_time: assert property (
    trim.start |=> !trim.start ##1 trim.done ##1 !trim.done)
    else $error("shared trim unit started twice in flight");

endmodule

// ---- verilog/dtl_pkg.sv ----
/*
  Shared constants and types for the DAC trim and load datapath: code widths,
  power-on defaults, channel grouping, write targets and timing.
  Assumes a single 200 MHz clock and the 16-bit code variant unless
  WIDE_VARIANT is cleared.
*/
package dtl_pkg;

  // variant choice: 1 = 16-bit codes, 0 = 14-bit codes
  localparam bit WIDE_VARIANT = 1'b1;
  localparam int CODE_W = WIDE_VARIANT ? 16 : 14;
  localparam int SPAN_W = 14;
  localparam int NET_W = CODE_W + 2;
  // span code scale: times four when codes are two bits wider than the span dac
  localparam int SPAN_SHIFT = CODE_W - SPAN_W;

  // channel organisation
  localparam int CH_N = 32;
  localparam int CH_W = 5;
  localparam int GROUP_N = 4;
  localparam int GROUP_SIZE = 8;

  // power-on defaults
  localparam logic [CODE_W-1:0] RAW_DEFAULT = CODE_W'(WIDE_VARIANT ? 32'h5554 : 32'h1555);
  localparam logic [CODE_W-1:0] GAIN_DEFAULT = CODE_W'((64'h1 << CODE_W) - 64'h1);
  localparam logic [CODE_W-1:0] OFFSET_DEFAULT = CODE_W'(64'h1 << (CODE_W - 1));
  localparam logic [SPAN_W-1:0] SPAN_DEFAULT = 14'h1555;
  localparam logic [7:0] SELECT_DEFAULT = 8'h00;

  // initialisation sequence length
  localparam int CLK_PERIOD_NS = 5;
  localparam int INIT_TIME_NS = 300000;
  localparam int INIT_CYCLES = INIT_TIME_NS / CLK_PERIOD_NS;

  // trim unit latency from start to done
  localparam int TRIM_LATENCY = 2;

  // write targets of the host write port
  typedef enum logic [2:0] {
    DTL_WR_RAW = 3'h0,
    DTL_WR_GAIN = 3'h1,
    DTL_WR_OFFSET = 3'h2,
    DTL_WR_SPAN0 = 3'h3,
    DTL_WR_SPAN1 = 3'h4,
    DTL_WR_SELECT = 3'h5
  } dtl_wr_kind_t;

  // recalculation sequencer states
  typedef enum logic [1:0] {
    DTL_SEQ_IDLE = 2'b01,
    DTL_SEQ_WAIT = 2'b10
  } dtl_seq_state_t;

endpackage

// ---- verilog/dtl_trim_if.sv ----
/*
  Carrier between the load core and the shared trim unit: one start pulse
  with operands, one done pulse with the saturated channel code.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface dtl_trim_if;
  logic start;
  logic [dtl_pkg::CODE_W-1:0] raw;
  logic [dtl_pkg::CODE_W-1:0] gain;
  logic [dtl_pkg::CODE_W-1:0] offset;
  logic done;
  logic [dtl_pkg::CODE_W-1:0] result;

  modport core (output start, output raw, output gain, output offset,
                input done, input result);
  modport unit (input start, input raw, input gain, input offset,
                output done, output result);
endinterface

// ---- verilog/dtl_trim_unit.sv ----
/*
  The single multiplier and adder shared by all channels. A start pulse
  launches one calculation; done pulses two cycles later with the result.
  Assumes the caller holds no second start while one is in flight.
*/
`timescale 1ns/1ps
module dtl_trim_unit (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // operands and result
  dtl_trim_if.unit trim
);

  localparam int W = dtl_pkg::CODE_W;
  localparam int SUM_W = W + 3;
  localparam logic [SUM_W-1:0] HALF = SUM_W'(64'h1 << (W - 1));
  localparam logic [SUM_W-1:0] TOP = SUM_W'((64'h1 << W) - 64'h1);

  logic [2*W:0] product;
  logic [W-1:0] offset_hold;
  logic stage1;
  logic [SUM_W-1:0] sum;

  // stage one: the one multiplier, gain plus one covers the full scale
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      product <= '0;
      offset_hold <= '0;
      stage1 <= 1'b0;
    end else begin
      stage1 <= trim.start;
      if (trim.start) begin
        product <= (2*W+1)'(trim.raw) * ((2*W+1)'(trim.gain) + (2*W+1)'(1));
        offset_hold <= trim.offset;
      end
    end
  end

  // divide by truncation, then offset add less half scale
  assign sum = SUM_W'(product[2*W:W]) + SUM_W'(offset_hold) - HALF;

  // stage two: clamp instead of wrapping
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trim.done <= 1'b0;
      trim.result <= '0;
    end else begin
      trim.done <= stage1;
      if (stage1) begin
        if (sum[SUM_W-1]) begin
          trim.result <= '0;
        end else if (sum > TOP) begin
          trim.result <= W'(TOP);
        end else begin
          trim.result <= W'(sum);
        end
      end
    end
  end

  a_trim_math: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    trim.start |-> ##2 trim.done && (trim.result == (
      (SUM_W'(((2*W+1)'($past(trim.raw, 2)) * ((2*W+1)'($past(trim.gain, 2)) + (2*W+1)'(1)))
        >> W) + SUM_W'($past(trim.offset, 2)) - HALF) > TOP ?
      (((SUM_W'(((2*W+1)'($past(trim.raw, 2)) * ((2*W+1)'($past(trim.gain, 2))
        + (2*W+1)'(1))) >> W) + SUM_W'($past(trim.offset, 2)) - HALF) >> (SUM_W - 1)) != 0
        ? W'(0) : W'(TOP)) :
      W'(SUM_W'(((2*W+1)'($past(trim.raw, 2)) * ((2*W+1)'($past(trim.gain, 2)) + (2*W+1)'(1)))
        >> W) + SUM_W'($past(trim.offset, 2)) - HALF))))
    else $error("trim result does not match the transfer function");

endmodule
